/* File: inc/ess_defs.svh */
// constants for the sign and spare-byte command block
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH
`define ESS_OP_SIGN 8'h41
`define ESS_OP_SPARE 8'h20
`define ESS_ST_OK 8'h00
`define ESS_ST_PARSE 8'h03
`define ESS_ST_ECC 8'h05
`define ESS_ST_EXEC 8'h0F
`define ESS_OFF_USER 8'h54
`define ESS_OFF_SEL 8'h55
`define ESS_MSG_LEN 6'd55
`define ESS_SIG_LEN 7'd64
`define ESS_PK_VALID 4'h5
`define ESS_B_EXT 7
`define ESS_B_SN 6
`define ESS_B_DEC 1
`define ESS_B_SEL 0
`define ESS_SIGN_MBZ 8'h3E
`define ESS_SPARE_MBZ 8'hFC
`define ESS_ONE 8'h01
`define ESS_ZERO 8'h00
`define ESS_A_CMD 8'h00
`define ESS_A_STAT 8'h04
`define ESS_A_RSP 8'h08
`define ESS_B_EXT_OK 0
`define ESS_B_INT_OK 1
`define ESS_B_SECRET 7
`define ESS_B_PRIVATE 0
`endif

/* File: inc/ess_pkg.sv */
// command type shared by both ends of the command link, and the key info type that only the device end takes
package ess_pkg;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] mode;
    logic [15:0] param2;
  } ess_cmd_t;
  typedef struct packed {
    logic [15:0] slot_config;
    logic [15:0] key_config;
    logic [7:0] flags;
    logic slot_locked;
    logic pub_curve_ok;
    logic pub_info;
    logic [3:0] validity;
  } ess_key_info_t;
endpackage

/* File: inc/ess_link_if.sv */
// command link between host controller and coprocessor
`timescale 1ns/100ps
`default_nettype none
interface ess_link_if;
  import ess_pkg::*;
  logic cmd_valid;
  logic cmd_ready;
  ess_cmd_t cmd;
  logic rsp_valid;
  logic rsp_last;
  logic [7:0] rsp_byte;
  modport device (input cmd_valid, input cmd, output cmd_ready,
    output rsp_valid, output rsp_last, output rsp_byte);
  modport host (output cmd_valid, output cmd, input cmd_ready,
    input rsp_valid, input rsp_last, input rsp_byte);
endinterface
`default_nettype wire

/* File: rtl/ess_device.sv */
// coprocessor end: sign and spare-byte update command handling
// How it works
// [R1] sign opcode 0x41, mode, two-byte key index
// [R2] external digest needs read-key bit 0
// [R3] internal message needs read-key bit 1
// [R4] internal needs digest from keygen or digest_generate_command
// [R5] internal signing fails while data unlocked
// [R6] slot must be private and secret
// [R7] ephemeral failure returns single ECC fault byte
// [R8] success returns 64 bytes R then S
// [R9] mode bit 6 includes or zeroes serial bytes
// [R10] host keeps mode bits 5..1 zero
// [R11] 55-byte message in fixed byte order
// [R12] flags byte packs four flags and key
// [R13] lock byte is 01 if slot locked
// [R14] pubkey-valid byte one only when validated
// [R15] only last used key config is signed
// [R16] message hashed then sent to signer
// [R17] spare opcode 0x20, mode and value layout
// [R18] decrement: silent if no limit, error if exhausted
// [R19] user byte written only when currently zero
// [R20] select byte checked only in check mode
// [R21] only the two spare bytes change
// [R22] spare update answers one zero byte
// [R23] nonzero must-be-zero field gives parse error
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ess_device (
  input wire logic pclk,
  input wire logic presetn,
  ess_link_if.device link,
  input wire logic data_locked,
  input wire logic select_check_mode,
  input wire logic digest_valid,
  input wire logic digest_from_gen,
  input wire logic [255:0] working_digest,
  input wire logic [71:0] serial_number,
  input wire ess_pkg::ess_key_info_t key_info,
  input wire logic [15:0] slot_config_sel,
  input wire logic [15:0] key_config_sel,
  input wire logic limit_enabled,
  input wire logic limit_exhausted,
  output logic limit_dec,
  output logic [3:0] limit_slot,
  output logic [3:0] key_sel,
  output logic hash_start,
  output logic [439:0] hash_msg,
  input wire logic hash_done,
  input wire logic [255:0] hash_digest,
  output logic sign_start,
  output logic sign_external,
  output logic [255:0] sign_digest,
  input wire logic sign_done,
  input wire logic sign_fault,
  input wire logic [511:0] sign_rs,
  output logic [7:0] user_spare_config_byte,
  output logic [7:0] device_select_config_byte
);
  import ess_pkg::*;
  typedef enum {S_IDLE, S_CHECK, S_HASH, S_SIGN, S_RSP} ess_state_t;
  typedef struct packed {
    ess_state_t st;
    ess_cmd_t cmd;
    logic [511:0] rsp;
    logic [6:0] rsp_len;
    logic [6:0] rsp_idx;
    logic [7:0] user_b;
    logic [7:0] sel_b;
    logic [439:0] msg;
    logic [255:0] dig;
    logic ext;
    logic hstart;
    logic sstart;
    logic dec;
  } ess_dev_st_t;
  ess_dev_st_t q, d;

  function automatic logic [511:0] one_byte(input logic [7:0] b);
    one_byte = {b, 504'd0};
  endfunction

  function automatic logic [439:0] build_msg(input ess_cmd_t c,
      input logic [255:0] dg, input logic [71:0] sn,
      input ess_key_info_t ki);
    logic [7:0] s [0:8];
    logic [47:0] snz;
    logic [7:0] pkv;
    for (int i = 0; i < 9; i++) begin
      s[i] = sn[71-8*i -: 8];
    end
    // [R9] serial bytes 2..7 masked unless mode bit 6
    snz = c.mode[`ESS_B_SN] ? {s[4], s[5], s[6], s[7], s[2], s[3]} : '0;
    // [R14] validated supported-curve key only
    pkv = (ki.pub_curve_ok && ki.pub_info &&
      ki.validity == `ESS_PK_VALID) ? `ESS_ONE : `ESS_ZERO;
    // [R11] fixed order; [R12] flags; [R13] lock byte; [R15] last key
    build_msg = {dg, `ESS_OP_SIGN, c.mode, c.param2, ki.slot_config,
      ki.key_config, ki.flags, 16'h0000, s[8], snz[47:16], s[0], s[1],
      snz[15:0], ki.slot_locked ? `ESS_ONE : `ESS_ZERO, pkv, `ESS_ZERO};
  endfunction

  assign key_sel = q.cmd.param2[3:0];
  assign limit_slot = q.cmd.param2[3:0];
  assign limit_dec = q.dec;
  assign hash_start = q.hstart;
  assign hash_msg = q.msg;
  assign sign_start = q.sstart;
  assign sign_external = q.ext;
  assign sign_digest = q.dig;
  assign user_spare_config_byte = q.user_b;
  assign device_select_config_byte = q.sel_b;
  assign link.cmd_ready = (q.st == S_IDLE);
  assign link.rsp_valid = (q.st == S_RSP);
  assign link.rsp_byte = q.rsp[511:504];
  assign link.rsp_last = (q.st == S_RSP) && (q.rsp_idx == q.rsp_len - 7'd1);

  always_comb begin
    d = q;
    d.hstart = 1'b0;
    d.sstart = 1'b0;
    d.dec = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (link.cmd_valid) begin
          d.cmd = link.cmd;
          d.st = S_CHECK;
        end
      end
      S_CHECK: begin
        d.rsp_len = 7'd1;
        d.rsp_idx = 7'd0;
        d.st = S_RSP;
        // [R1] sign opcode decode
        if (q.cmd.opcode == `ESS_OP_SIGN) begin
          d.ext = q.cmd.mode[`ESS_B_EXT];
          // [R23] [R10] reserved mode bits
          if ((q.cmd.mode & `ESS_SIGN_MBZ) != `ESS_ZERO)
            d.rsp = one_byte(`ESS_ST_PARSE);
          // [R6] private and secret slot
          else if (!key_config_sel[`ESS_B_PRIVATE] ||
              !slot_config_sel[`ESS_B_SECRET])
            d.rsp = one_byte(`ESS_ST_EXEC);
          // [R2] external permission
          else if (q.cmd.mode[`ESS_B_EXT]) begin
            if (!slot_config_sel[`ESS_B_EXT_OK])
              d.rsp = one_byte(`ESS_ST_EXEC);
            else begin
              d.dig = working_digest;
              d.sstart = 1'b1;
              d.st = S_SIGN;
            end
          end
          // [R3] [R4] [R5] internal permission and source
          else if (!slot_config_sel[`ESS_B_INT_OK] || !data_locked ||
              !digest_valid || !digest_from_gen)
            d.rsp = one_byte(`ESS_ST_EXEC);
          else begin
            // [R16] hash before signing
            d.msg = build_msg(q.cmd, working_digest, serial_number, key_info);
            d.hstart = 1'b1;
            d.st = S_HASH;
          end
        end else if (q.cmd.opcode == `ESS_OP_SPARE) begin
          // [R23] [R17] reserved mode bits and value high byte
          if ((q.cmd.mode & `ESS_SPARE_MBZ) != `ESS_ZERO ||
              q.cmd.param2[15:8] != `ESS_ZERO)
            d.rsp = one_byte(`ESS_ST_PARSE);
          // [R18] decrement limited-use counter
          else if (q.cmd.mode[`ESS_B_DEC]) begin
            if (!limit_enabled)
              d.rsp = one_byte(`ESS_ST_OK);
            else if (limit_exhausted)
              d.rsp = one_byte(`ESS_ST_EXEC);
            else begin
              d.dec = 1'b1;
              d.rsp = one_byte(`ESS_ST_OK);
            end
          end
          // [R20] select byte
          else if (q.cmd.mode[`ESS_B_SEL]) begin
            if (select_check_mode && q.sel_b == `ESS_ZERO)
              d.rsp = one_byte(`ESS_ST_EXEC);
            else begin
              d.sel_b = q.cmd.param2[7:0];
              d.rsp = one_byte(`ESS_ST_OK);
            end
          end
          // [R19] [R21] [R22] user byte written once
          else if (q.user_b != `ESS_ZERO)
            d.rsp = one_byte(`ESS_ST_EXEC);
          else begin
            d.user_b = q.cmd.param2[7:0];
            d.rsp = one_byte(`ESS_ST_OK);
          end
        end else
          d.rsp = one_byte(`ESS_ST_PARSE);
      end
      S_HASH: begin
        if (hash_done) begin
          d.dig = hash_digest;
          d.sstart = 1'b1;
          d.st = S_SIGN;
        end
      end
      S_SIGN: begin
        if (sign_done) begin
          d.rsp_idx = 7'd0;
          d.st = S_RSP;
          // [R7] single fault byte
          if (sign_fault) begin
            d.rsp = one_byte(`ESS_ST_ECC);
            d.rsp_len = 7'd1;
          end else begin
            // [R8] R then S
            d.rsp = sign_rs;
            d.rsp_len = `ESS_SIG_LEN;
          end
        end
      end
      S_RSP: begin
        d.rsp = {q.rsp[503:0], 8'h00};
        d.rsp_idx = q.rsp_idx + 7'd1;
        if (q.rsp_idx == q.rsp_len - 7'd1)
          d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= '{st: S_IDLE, default: '0};
    else
      q <= d;
  end
endmodule
`default_nettype wire

/* File: rtl/ess_host.sv */
// host end: APB command registers driving the command link
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ess_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ess_link_if.host link
);
  import ess_pkg::*;
  // register offsets: 00 command, 04 status, 08 response fifo window
  localparam logic [7:0] A_CMD = `ESS_A_CMD;
  localparam logic [7:0] A_STAT = `ESS_A_STAT;
  localparam logic [7:0] A_RSP = `ESS_A_RSP;
  typedef struct packed {
    ess_cmd_t cmd;
    logic busy;
    logic done;
    logic [6:0] cnt;
    logic [7:0] last_byte;
    logic [7:0] rd_ptr;
    logic [511:0] buf_b;
    logic [31:0] rdata;
  } ess_host_st_t;
  ess_host_st_t q, d;
  logic acc;

  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && paddr != A_CMD && paddr != A_STAT &&
    paddr != A_RSP;
  assign prdata = q.rdata;
  assign link.cmd_valid = q.busy && !q.done && q.cnt == 7'd0 &&
    q.rd_ptr == 8'hFF;
  assign link.cmd = q.cmd;

  always_comb begin
    d = q;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        A_STAT: d.rdata = {16'h0000, q.last_byte, q.busy, q.cnt};
        A_RSP: d.rdata = q.buf_b[511:480];
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite && paddr == A_CMD && !q.busy) begin
      d.cmd = pwdata;
      d.busy = 1'b1;
      d.done = 1'b0;
      d.cnt = 7'd0;
      d.rd_ptr = 8'hFF;
    end
    // one request per command; a read of the window shifts a word out
    if (acc && !pwrite && paddr == A_RSP)
      d.buf_b = {q.buf_b[479:0], 32'h0000_0000};
    if (link.cmd_valid && link.cmd_ready)
      d.rd_ptr = 8'h00;
    if (link.rsp_valid) begin
      d.buf_b[511 - 8*q.cnt[5:0] -: 8] = link.rsp_byte;
      d.last_byte = link.rsp_byte;
      d.cnt = q.cnt + 7'd1;
      if (link.rsp_last) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= '{rd_ptr: 8'hFF, default: '0};
    else
      q <= d;
  end
endmodule
`default_nettype wire

/* File: test/ess_sva.sv */
// link protocol checks for the sign and spare-byte command block
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ess_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire ess_pkg::ess_cmd_t cmd,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte
);
  import ess_pkg::*;
  logic [7:0] op_q;
  logic [6:0] cnt_q;
  wire logic take;
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // opcode of the command whose answer is streaming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
      cnt_q <= 7'h00;
    end else begin
      if (take) op_q <= cmd.opcode;
      if (rsp_valid) cnt_q <= rsp_last ? 7'h00 : cnt_q + 7'h01;
    end
  end
  sequence parse_reply;
    rsp_valid && rsp_last && rsp_byte == `ESS_ST_PARSE;
  endsequence
  sequence spare_take;
    take && cmd.opcode == `ESS_OP_SPARE;
  endsequence
  sequence sign_take;
    take && cmd.opcode == `ESS_OP_SIGN;
  endsequence
  AST_SPARE_MBZ: assert property (spare_take ##0
    (cmd.mode & `ESS_SPARE_MBZ) != 8'h00 |-> ##2 parse_reply)
    else $error("spare mode bits not refused");
  AST_SPARE_HI: assert property (spare_take ##0
    cmd.param2[15:8] != 8'h00 |-> ##2 parse_reply)
    else $error("spare high byte not refused");
  AST_SIGN_MBZ: assert property (sign_take ##0
    (cmd.mode & `ESS_SIGN_MBZ) != 8'h00 |-> ##2 parse_reply)
    else $error("sign mode bits not refused");
  AST_SPARE_ONE: assert property (
    rsp_valid && op_q == `ESS_OP_SPARE |-> rsp_last)
    else $error("spare answer longer than one byte");
  AST_SIGN_LEN: assert property (
    rsp_last && op_q == `ESS_OP_SIGN |-> cnt_q == 7'd0 || cnt_q == 7'd63)
    else $error("sign answer length wrong");
  AST_LAST: assert property (rsp_last |-> rsp_valid)
    else $error("last without valid");
  AST_STREAM: assert property (rsp_valid && !rsp_last |=> rsp_valid)
    else $error("answer stream broken");
  AST_ONE_CMD: assert property (rsp_valid |-> !cmd_ready)
    else $error("ready while answering");
  AST_HOLD: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd))
    else $error("command dropped before take");
  AST_ONE_TAKE: assert property (take |=> !cmd_valid)
    else $error("command offered twice");
endmodule
`default_nettype wire

/* File: test/ecdsa_sign_and_spare_byte_update_test.sv */
// self-checking bench joining host and device ends
`include "ess_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module ecdsa_sign_and_spare_byte_update_test;
  import ess_pkg::*;
  localparam logic [255:0] WD = {8{32'h1F2E3D4C}};
  localparam logic [255:0] HD = {8{32'hC0DEF00D}};
  localparam logic [71:0] SN = 72'h0102030405060708A9;
  localparam logic [511:0] RS = {16{32'h1122335A}};
  localparam ess_key_info_t KI = '{16'h1234, 16'h5678, 8'hA3,
    1'b1, 1'b1, 1'b1, 4'h5};
  localparam logic [439:0] EXP = {WD, 8'h41, 8'h40, 16'h0003,
    KI.slot_config, KI.key_config, KI.flags, 16'h0000, SN[7:0],
    SN[39:8], SN[71:56], SN[55:40], 8'h01, 8'h01, 8'h00};
  // serial bytes masked, slot unlocked, key not validated
  localparam logic [439:0] EXP0 = {WD, 8'h41, 8'h00, 16'h0003,
    KI.slot_config, KI.key_config, KI.flags, 16'h0000, SN[7:0],
    32'h0000_0000, SN[71:56], 16'h0000, 8'h00, 8'h00, 8'h00};
  ess_key_info_t ki = KI;
  logic [3:0] dec_cnt = 4'h0;
  logic [3:0] dec_slot = 4'h0;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, limit_dec, hash_start, sign_start, sign_ext;
  logic hash_done = 1'b0;
  logic sign_done = 1'b0;
  logic scm = 1'b0;
  logic [11:0] cfg = 12'h000;
  logic [7:0] usr, dsel, st;
  logic [3:0] limit_slot, key_sel;
  logic [439:0] hash_msg, msg_q;
  logic [255:0] sign_digest;
  // cmd, cfg, expected last byte
  logic [51:0] rows [14] = '{
    52'h41800003_015_5A, 52'h41800003_014_0F,
    52'h41400003_11E_5A, 52'h41400003_11C_0F,
    52'h41400003_116_0F, 52'h41400003_01E_0F,
    52'h41400003_11A_0F, 52'h41400003_19E_05,
    52'h41820003_11E_03, 52'h20020005_020_00,
    52'h20020005_000_00, 52'h20020005_060_0F,
    52'h20100000_000_03, 52'h20000100_000_03};
  int failures = 0;
  int comparisons = 0;
  ess_link_if u_ess_link_if ();
  ess_host u_ess_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(u_ess_link_if.host));
  ess_device u_ess_device (.pclk(pclk), .presetn(presetn),
    .link(u_ess_link_if.device), .data_locked(cfg[3]),
    .select_check_mode(scm), .digest_valid(cfg[4]),
    .digest_from_gen(cfg[8]), .working_digest(WD), .serial_number(SN),
    .key_info(ki), .slot_config_sel({8'h00, cfg[2], 5'h00, cfg[1:0]}),
    .key_config_sel({15'h0000, cfg[2]}), .limit_enabled(cfg[5]),
    .limit_exhausted(cfg[6]), .limit_dec(limit_dec),
    .limit_slot(limit_slot), .key_sel(key_sel), .hash_start(hash_start),
    .hash_msg(hash_msg), .hash_done(hash_done), .hash_digest(HD),
    .sign_start(sign_start), .sign_external(sign_ext),
    .sign_digest(sign_digest), .sign_done(sign_done),
    .sign_fault(cfg[7]), .sign_rs(RS), .user_spare_config_byte(usr),
    .device_select_config_byte(dsel));
  ess_sva u_ess_sva (.pclk(pclk), .presetn(presetn),
    .cmd_valid(u_ess_link_if.cmd_valid), .cmd(u_ess_link_if.cmd),
    .cmd_ready(u_ess_link_if.cmd_ready),
    .rsp_valid(u_ess_link_if.rsp_valid),
    .rsp_last(u_ess_link_if.rsp_last), .rsp_byte(u_ess_link_if.rsp_byte));
  always #4 pclk = ~pclk;
  // engines answer one cycle after start
  always @(posedge pclk) begin
    hash_done <= hash_start;
    sign_done <= sign_start;
    if (hash_start === 1'b1) msg_q <= hash_msg;
    // decrement pulse lasts one cycle, so count it here
    if (limit_dec === 1'b1) begin
      dec_cnt <= dec_cnt + 4'h1;
      dec_slot <= limit_slot;
    end
  end
  task automatic chk(input logic [439:0] s, input logic [439:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // busy is polled, so no latency is assumed
  task automatic run(input logic [31:0] c, input logic [11:0] f);
    cfg <= f;
    apb(1'b1, 8'h00, c);
    rd = 32'h80;
    while (rd[7] !== 1'b0) apb(1'b0, 8'h04, 32'h0);
    st = rd[15:8];
  endtask
  task complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i][51:20], rows[i][19:8]);
      chk(st, rows[i][7:0]);
    end
    chk({dec_cnt, dec_slot}, 8'h15);
    run(32'h41800003, 12'h015);
    chk({sign_ext, sign_digest}, {1'b1, WD});
    run(32'h41400003, 12'h11E);
    chk(msg_q, EXP);
    chk(sign_digest, HD);
    chk(key_sel, 4'h3);
    chk(sign_ext, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, RS[511:480]);
    ki.slot_locked <= 1'b0;
    ki.validity <= 4'hA;
    run(32'h41000003, 12'h11E);
    chk(msg_q, EXP0);
    run(32'h200000A5, 12'h000);
    chk({st, usr}, 16'h00A5);
    run(32'h2000005B, 12'h000);
    chk({st, usr}, 16'h0FA5);
    run(32'h2001003C, 12'h000);
    chk({st, dsel, usr}, 24'h003CA5);
    scm <= 1'b1;
    run(32'h20010077, 12'h000);
    chk({st, dsel}, 16'h0077);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({usr, dsel}, 16'h0000);
    presetn <= 1'b1;
    run(32'h20010011, 12'h000);
    chk({st, dsel}, 16'h0F00);
    complete_run;
  end
endmodule
`default_nettype wire
